// file: rtl/fas_regs.sv
// Operation
// RULE1 - legacy zero field reads zero, ignores writes
// RULE2 - old-release zero field never hardware updated
// RULE3 - software writes only zero to old field
// RULE4 - old-release zero field reads zero
// RULE5 - software zeroes undefined-reset field before reading
// RULE6 - nonzero write to clear-only bit ignored
// RULE7 - zero write clears clear-only bit
// RULE8 - hardware may set or clear clear-only bit
// RULE9 - software writes one to keep clear-only bit
// RULE10 - clear-only bit reads its current state
// RULE11 - ignored field leaves other field writes intact
// RULE12 - reserved field reads zero, resets zero
// RULE13 - write enables computed per bit
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "fas_params.svh"

module fas_regs (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // register port
  input  wire fas_pkg::fas_bus_req_t bus_req,
  output logic [`FAS_DATA_W-1:0]    rdata,
  // hardware requests on clear-only bits
  input  wire fas_pkg::fas_co_req_t co_req,
  // field state towards the core
  output logic [`FAS_RW_W-1:0]      rw_field_out,
  output logic [`FAS_CO_W-1:0]      clear_only_field_out
);
  import fas_pkg::*;

  fas_rw_t   rw_r;
  fas_rw_t   rw_nxt;
  fas_co_t   co_r;
  fas_co_t   co_nxt;
  fas_word_t rdata_r;
  fas_word_t rdata_nxt;
  fas_word_t bit_we;
  fas_co_t   co_sw_clr;

  // reset image of the clear-only field, indexed per bit below
  localparam fas_co_t CO_RST = `FAS_CO_RST;

  // address match for the control word
  function automatic logic ctrl_hit(input fas_addr_t a);
    ctrl_hit = (a == `FAS_CTRL_OFF);
  endfunction

  // per-bit write enables: only read-write and clear-only bits are writable
  function automatic fas_word_t field_we(input fas_bus_req_t r);
    fas_word_t m;
    m = '0;
    if (r.wr && ctrl_hit(r.addr)) begin
      m[`FAS_RW_MSB:`FAS_RW_LSB] = '1;
      m[`FAS_CO_MSB:`FAS_CO_LSB] = '1;
    end
    field_we = m;
  endfunction

  // assemble the read image; zero fields are constant zero
  function automatic fas_word_t read_image(input fas_rw_t rw, input fas_co_t co);
    fas_word_t w;
    w = '0;
    w[`FAS_RW_MSB:`FAS_RW_LSB] = rw;
    w[`FAS_CO_MSB:`FAS_CO_LSB] = co;
    read_image = w;
  endfunction

  always_comb begin
    bit_we = field_we(bus_req); // RULE13
  end

  // read-write field: each bit follows its own enable
  always_comb begin
    rw_nxt = rw_r;
    if (rst) begin
      rw_nxt = `FAS_RW_RST;
    end else begin
      for (int i = 0; i < `FAS_RW_W; i++) begin
        if (bit_we[`FAS_RW_LSB+i]) begin
          rw_nxt[i] = bus_req.wdata[`FAS_RW_LSB+i]; // RULE11
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    rw_r <= rw_nxt;
  end

  // clear-only bits: hardware set wins, then hardware clear, then software zero
  generate
    for (genvar g = 0; g < `FAS_CO_W; g++) begin : g_co
      always_comb begin
        co_sw_clr[g] = bit_we[`FAS_CO_LSB+g] && !bus_req.wdata[`FAS_CO_LSB+g]; // RULE7 RULE6
        co_nxt[g]    = co_r[g];
        if (rst) begin
          co_nxt[g] = CO_RST[g];
        end else if (co_req.set[g]) begin
          co_nxt[g] = 1'b1; // RULE8
        end else if (co_req.clr[g]) begin
          co_nxt[g] = 1'b0; // RULE8
        end else if (co_sw_clr[g]) begin
          co_nxt[g] = 1'b0; // RULE7
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    co_r <= co_nxt;
  end

  // read data stands for the single cycle after the strobe
  always_comb begin
    rdata_nxt = `FAS_RD_RST;
    if (!rst && bus_req.rd) begin
      if (ctrl_hit(bus_req.addr)) begin
        rdata_nxt = read_image(rw_r, co_r); // RULE1 RULE2 RULE4 RULE10 RULE12
      end else begin
        rdata_nxt = `FAS_RD_RST;
      end
    end
  end

  always_ff @(posedge clk) begin
    rdata_r <= rdata_nxt;
  end

  assign rdata                = rdata_r;
  assign rw_field_out         = rw_r;
  assign clear_only_field_out = co_r;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic    ctrl_wr;
  logic    ctrl_rd;
  fas_co_t co_keep_mask;
  assign ctrl_wr      = bus_req.wr && ctrl_hit(bus_req.addr);
  assign ctrl_rd      = bus_req.rd && ctrl_hit(bus_req.addr);
  assign co_keep_mask = bus_req.wdata[`FAS_CO_MSB:`FAS_CO_LSB] & ~co_req.set & ~co_req.clr;

  sequence s_ctrl_read;
    ctrl_rd;
  endsequence

  sequence s_ctrl_write;
    ctrl_wr;
  endsequence

  a_lz_read_zero: assert property (s_ctrl_read |=> rdata[`FAS_LZ_MSB:`FAS_LZ_LSB] == '0) // RULE1
    else $error("legacy zero field read nonzero");
  a_lz_write_kept: assert property (s_ctrl_write ##1 s_ctrl_read |=> rdata[`FAS_LZ_MSB:`FAS_LZ_LSB] == '0) // RULE1
    else $error("legacy zero field took a write");
  a_pz_no_update: assert property (s_ctrl_write ##1 s_ctrl_read |=> rdata[`FAS_PZ_MSB:`FAS_PZ_LSB] == '0) // RULE2
    else $error("old-release zero field was updated");
  a_pz_read_zero: assert property (s_ctrl_read |=> rdata[`FAS_PZ_MSB:`FAS_PZ_LSB] == '0) // RULE4
    else $error("old-release zero field read nonzero");
  a_co_nz_ignored: assert property (s_ctrl_write |=> (co_r & $past(co_keep_mask)) == ($past(co_r) & $past(co_keep_mask))) // RULE6
    else $error("nonzero write changed a clear-only bit");
  a_co_zero_clear: assert property (s_ctrl_write ##0 (co_sw_clr & ~co_req.set) != '0
                                    |=> (co_r & $past(co_sw_clr & ~co_req.set)) == '0) // RULE7
    else $error("zero write did not clear a clear-only bit");
  a_co_hw_set: assert property (co_req.set != '0 |=> (co_r & $past(co_req.set)) == $past(co_req.set)) // RULE8
    else $error("hardware set lost");
  a_co_hw_clear: assert property (co_req.clr != '0 ##0 co_req.set == '0 |=> (co_r & $past(co_req.clr)) == '0) // RULE8
    else $error("hardware clear lost");
  a_co_read_state: assert property (s_ctrl_read |=> rdata[`FAS_CO_MSB:`FAS_CO_LSB] == $past(co_r)) // RULE10
    else $error("clear-only read does not show state");
  a_rw_still_written: assert property (s_ctrl_write |=> rw_r == $past(bus_req.wdata[`FAS_RW_MSB:`FAS_RW_LSB])) // RULE11 RULE13
    else $error("read-write field missed a write");
  a_rz_read_zero: assert property (s_ctrl_read |=> rdata[`FAS_RZ_MSB:`FAS_RZ_LSB] == '0) // RULE12
    else $error("reserved field read nonzero");
  a_rd_one_cycle: assert property (!bus_req.rd |=> rdata == '0)
    else $error("read data outside its cycle");

  // reset images; these stay armed while reset is high
  a_rst_rw_zero: assert property (disable iff (1'b0) rst
                                  |=> rw_r == '0)
    else $error("read-write field not zero after reset");
  a_rst_co_zero: assert property (disable iff (1'b0) rst
                                  |=> co_r == '0) // RULE8
    else $error("clear-only field not zero after reset");
  a_rst_rdata_zero: assert property (disable iff (1'b0) rst
                                     |=> rdata == '0) // RULE12
    else $error("read data not zero after reset");

  // zero fields never show anything but zero
  a_lz_always_zero: assert property (
                      rdata[`FAS_LZ_MSB:`FAS_LZ_LSB] == '0) // RULE1
    else $error("legacy zero field showed nonzero");
  a_pz_always_zero: assert property (
                      rdata[`FAS_PZ_MSB:`FAS_PZ_LSB] == '0) // RULE2 RULE4
    else $error("old-release zero field showed nonzero");
  a_unmapped_rd: assert property (bus_req.rd && !ctrl_hit(bus_req.addr)
                                  |=> rdata == '0) // RULE12
    else $error("unmapped read returned data");

  // field state moves only when its own enables say so, or for clear-only bits on a hardware set or clear request
  a_rw_hold: assert property (!ctrl_wr
                              |=> rw_r == $past(rw_r)) // RULE13
    else $error("read-write field changed without a write");
  a_co_no_spont_set: assert property (co_req.set == '0
                                      |=> (co_r & ~$past(co_r)) == '0) // RULE6
    else $error("clear-only bit set without hardware request");
  a_unmapped_wr: assert property (bus_req.wr && !ctrl_hit(bus_req.addr) && co_req == '0
                                  |=> co_r == $past(co_r) && rw_r == $past(rw_r)) // RULE13
    else $error("unmapped write changed a field");
  a_co_sw_only: assert property (s_ctrl_write ##0 co_req == '0
                                 |=> co_r == ($past(co_r) & ~$past(co_sw_clr))) // RULE6 RULE7
    else $error("software write left wrong clear-only bits");
  a_rw_read_state: assert property (s_ctrl_read
                                    |=> rdata[`FAS_RW_MSB:`FAS_RW_LSB] == $past(rw_r)) // RULE11
    else $error("read-write read does not show state");

endmodule

// file: inc/fas_params.svh
`ifndef FAS_PARAMS_SVH
`define FAS_PARAMS_SVH

// bus geometry
`define FAS_ADDR_W   8
`define FAS_DATA_W   32

// register offsets
`define FAS_CTRL_OFF 8'h00

// control word field layout
`define FAS_RW_LSB   0
`define FAS_RW_MSB   7
`define FAS_LZ_LSB   8
`define FAS_LZ_MSB   11
`define FAS_PZ_LSB   12
`define FAS_PZ_MSB   15
`define FAS_CO_LSB   16
`define FAS_CO_MSB   19
`define FAS_RZ_LSB   20
`define FAS_RZ_MSB   31

// field widths
`define FAS_RW_W     8
`define FAS_CO_W     4

// reset values
`define FAS_RW_RST   8'h00
`define FAS_CO_RST   4'h0
`define FAS_RD_RST   32'h0000_0000

`endif

// file: inc/fas_pkg.sv
`include "fas_params.svh"

package fas_pkg;

  typedef logic [`FAS_ADDR_W-1:0] fas_addr_t;
  typedef logic [`FAS_DATA_W-1:0] fas_word_t;
  typedef logic [`FAS_RW_W-1:0]   fas_rw_t;
  typedef logic [`FAS_CO_W-1:0]   fas_co_t;

  // one software access: address, data and the two strobes
  typedef struct packed {
    fas_addr_t addr;
    fas_word_t wdata;
    logic      wr;
    logic      rd;
  } fas_bus_req_t;

  // hardware-side requests on the clear-only bits
  typedef struct packed {
    fas_co_t set;
    fas_co_t clr;
  } fas_co_req_t;

endpackage

// file: testbench/tb_fas_regs.sv
`timescale 1ns/1ps
`include "fas_params.svh"

module tb_fas_regs;
  import fas_pkg::*;
  logic         clk         = 1'b0;
  logic         rst         = 1'b1;
  fas_bus_req_t bus_req     = '0;
  fas_co_req_t  co_req      = '0;
  fas_word_t    rdata;
  fas_rw_t      rw_field_out;
  fas_co_t      clear_only_field_out;
  fas_word_t    rd_val;
  int           miscompares = 0;
  int           check_count = 0;

  always #5 clk = ~clk;

  fas_regs fas_regs_inst (
    .clk                  (clk),
    .rst                  (rst),
    .bus_req              (bus_req),
    .rdata                (rdata),
    .co_req               (co_req),
    .rw_field_out         (rw_field_out),
    .clear_only_field_out (clear_only_field_out)
  );

  task automatic chk(input fas_word_t seen, input fas_word_t exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic bus_wr(input fas_addr_t a, input fas_word_t d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input fas_addr_t a, output fas_word_t d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1;
    d = rdata;
  endtask

  task automatic hw(input fas_co_t s, input fas_co_t c);
    @(posedge clk);
    co_req <= '{set: s, clr: c};
    @(posedge clk);
    co_req <= '0;
    #1;
  endtask

  task automatic t_reset;
    chk(rdata, 32'h0000_0000);
    chk(32'(rw_field_out), 32'h0000_0000);
    chk(32'(clear_only_field_out), 32'h0000_0000);
    bus_wr(8'h00, 32'h0000_0000);
    bus_rd(8'h00, rd_val);
    chk(rd_val, 32'h0000_0000);
  endtask

  // all-ones write except a zero old-release field, with hardware-set clear-only bits
  task automatic t_ones;
    hw(4'hF, 4'h0);
    chk(32'(clear_only_field_out), 32'h0000_000F);
    bus_wr(8'h00, 32'hFFFF_0FFF);
    chk(32'(clear_only_field_out), 32'h0000_000F);
    chk(32'(rw_field_out), 32'h0000_00FF);
    bus_rd(8'h00, rd_val);
    chk(rd_val, 32'h000F_00FF);
    @(posedge clk);
    #1;
    chk(rdata, 32'h0000_0000);
  endtask

  // zero bits clear only their own positions
  task automatic t_clear;
    bus_wr(8'h00, 32'hFFFA_0F5A);
    chk(32'(clear_only_field_out), 32'h0000_000A);
    chk(32'(rw_field_out), 32'h0000_005A);
    bus_rd(8'h00, rd_val);
    chk(rd_val, 32'h000A_005A);
  endtask

  task automatic t_hw;
    hw(4'h0, 4'h8);
    chk(32'(clear_only_field_out), 32'h0000_0002);
    hw(4'h1, 4'h1);
    chk(32'(clear_only_field_out), 32'h0000_0003);
  endtask

  task automatic t_unmapped;
    bus_wr(8'h04, 32'h0000_0000);
    chk(32'(rw_field_out), 32'h0000_005A);
    chk(32'(clear_only_field_out), 32'h0000_0003);
    bus_rd(8'h04, rd_val);
    chk(rd_val, 32'h0000_0000);
  endtask

  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_ones();
    t_clear();
    t_hw();
    t_unmapped();
    tally_and_finish();
  end
endmodule
